/* src/clq_pkg.sv */
// package for the current limit configuration qualifier
// assumes a 10 MHz core clock; shared by the design and the bench
package clq_pkg;
  localparam int CLOCK_MHZ = 10;
  localparam int BLANK_GND_NS = 672;
  localparam int BLANK_WIND_NS = 352;
  localparam int BLANK_GND_CYC = (BLANK_GND_NS * CLOCK_MHZ + 999) / 1000;
  localparam int BLANK_WIND_CYC = (BLANK_WIND_NS * CLOCK_MHZ + 999) / 1000;
  localparam int LEVEL_VIOL_ALLOWED = 4;
  localparam int CODE_GROUP_SIZE = 8;
  localparam int CNT_W = 5;
  localparam int BLANK_W = 8;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_ACTIVE = 4'h3;
  // ctrl field positions
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_METHOD_LSB = 1;
  localparam int CTRL_BLANK_LSB = 4;
  localparam int CTRL_VIOL_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // status bits
  localparam int ST_FAULT = 0;
  localparam int ST_VIOL = 1;

  typedef enum logic [1:0] {
    CLQ_LEVEL_LOW,
    CLQ_LEVEL_OPEN,
    CLQ_LEVEL_HIGH
  } clq_level_t;

  typedef enum logic [1:0] {
    CLQ_GND_SWITCH,
    CLQ_WIND_DOWN,
    CLQ_WIND_UP
  } clq_method_t;

  typedef struct packed {
    logic a_has_resistor;
    logic b_is_resistor;
    clq_level_t b_level;
    logic [4:0] b_code;
  } clq_strap_t;

  typedef struct packed {
    clq_method_t method;
    logic [BLANK_W-1:0] blank_cycles;
    logic [CNT_W-1:0] viol_allowed;
  } clq_cfg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } clq_bus_t;
endpackage

/* src/clq_qualifier.sv */
// current limit configuration qualifier: strap decode, blanking, violation count, fault
// assumes comparator and window inputs synchronous to clock; straps stable after reset
//
// Operation
// - finite resistor on strap a: strap b level picks method, blanking, four violations
// - no resistor on strap a: ignore strap b, use ground switch sensing
// - lowest eight strap b codes: ground switch, 672 ns, odd counts 1 to 15
// - middle eight codes: down-slope winding sensing, 352 ns, odd counts 1 to 15
// - highest eight codes: up-slope winding sensing, 352 ns, odd counts 1 to 15
// - during blanking take no measurement, ignore comparator; blanking length configurable
// - count violations, declare fault only after allowed count is exceeded
// - host written sensing method overrides the strapped one
// - sample current only inside the sensing window for the chosen method
`timescale 1ns/10ps
module clq_qualifier
  import clq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // strap decoder
  input wire clq_strap_t strap,
  // sensing windows from the switching controller
  input wire logic low_side_on,
  input wire logic down_slope_win,
  input wire logic up_slope_win,
  // comparator
  input wire logic over_limit,
  // register port
  input wire clq_bus_t bus,
  output logic [31:0] rdata,
  // results
  output clq_method_t active_method,
  output logic sample_valid,
  output logic fault,
  output logic irq
);

  clq_cfg_t strap_cfg;
  clq_cfg_t next_strap_cfg;
  logic [31:0] ctrl;
  logic [1:0] status;
  logic [1:0] mask;
  logic [BLANK_W-1:0] blank_cnt;
  logic [CNT_W-1:0] viol_cnt;
  logic win_d;
  logic strap_taken;
  logic window;
  logic win_start;
  logic meas;
  logic viol_ev;
  logic fault_ev;
  clq_method_t method;
  logic [BLANK_W-1:0] blank_len;
  logic [CNT_W-1:0] allowed;

  // odd allowed count for a resistor code within its group
  function automatic logic [CNT_W-1:0] odd_count(input logic [4:0] code);
    odd_count = CNT_W'({code[2:0], 1'b1});
  endfunction

  function automatic logic [BLANK_W-1:0] blank_for(input clq_method_t m);
    blank_for = (m == CLQ_GND_SWITCH) ? BLANK_W'(BLANK_GND_CYC) : BLANK_W'(BLANK_WIND_CYC);
  endfunction

  always_comb begin
    next_strap_cfg.method = CLQ_GND_SWITCH;
    next_strap_cfg.viol_allowed = CNT_W'(LEVEL_VIOL_ALLOWED);
    if (!strap.a_has_resistor) begin
      next_strap_cfg.method = CLQ_GND_SWITCH;
    end else if (strap.b_is_resistor) begin
      if (strap.b_code < 5'(CODE_GROUP_SIZE)) begin
        next_strap_cfg.method = CLQ_GND_SWITCH;
      end else if (strap.b_code < 5'(2 * CODE_GROUP_SIZE)) begin
        next_strap_cfg.method = CLQ_WIND_DOWN;
      end else begin
        next_strap_cfg.method = CLQ_WIND_UP;
      end
      next_strap_cfg.viol_allowed = odd_count(strap.b_code);
    end else begin
      unique case (strap.b_level)
        CLQ_LEVEL_LOW: next_strap_cfg.method = CLQ_GND_SWITCH;
        CLQ_LEVEL_OPEN: next_strap_cfg.method = CLQ_WIND_DOWN;
        CLQ_LEVEL_HIGH: next_strap_cfg.method = CLQ_WIND_UP;
        default: next_strap_cfg.method = CLQ_GND_SWITCH;
      endcase
    end
    next_strap_cfg.blank_cycles = blank_for(next_strap_cfg.method);
  end

  // straps caught once, first edge after reset release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_cfg <= '0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_cfg <= next_strap_cfg;
      strap_taken <= 1'b1;
    end
  end

  // zero blanking and count fields in ctrl fall back to the strapped value; method falls back only while the override bit is clear
  always_comb begin
    method = ctrl[CTRL_OVR_BIT] ? clq_method_t'(ctrl[CTRL_METHOD_LSB +: 2]) : strap_cfg.method;
    blank_len = (ctrl[CTRL_BLANK_LSB +: BLANK_W] != '0) ? ctrl[CTRL_BLANK_LSB +: BLANK_W]
                                                         : strap_cfg.blank_cycles;
    allowed = (ctrl[CTRL_VIOL_LSB +: CNT_W] != '0) ? ctrl[CTRL_VIOL_LSB +: CNT_W] : strap_cfg.viol_allowed;
    unique case (method)
      CLQ_WIND_DOWN: window = down_slope_win;
      CLQ_WIND_UP: window = up_slope_win;
      default: window = low_side_on;
    endcase
  end

  assign win_start = window && !win_d;
  assign meas = strap_taken && window && !win_start && (blank_cnt == '0);
  assign viol_ev = meas && over_limit;
  assign fault_ev = viol_ev && (viol_cnt >= allowed) && !fault;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      win_d <= 1'b0;
    end else begin
      win_d <= window;
    end
  end

  // blanking counter restarts at each window start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blank_cnt <= '0;
    end else if (win_start) begin
      blank_cnt <= blank_len - BLANK_W'(1);
    end else if (!window) begin
      blank_cnt <= '0;
    end else if (blank_cnt != '0) begin
      blank_cnt <= blank_cnt - BLANK_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      viol_cnt <= '0;
    end else if (meas && !over_limit) begin
      viol_cnt <= '0;
    end else if (viol_ev && viol_cnt != '1) begin
      viol_cnt <= viol_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault <= 1'b0;
      sample_valid <= 1'b0;
      active_method <= CLQ_GND_SWITCH;
    end else begin
      if (fault_ev) begin
        fault <= 1'b1;
      end else if (bus.wr && bus.addr == REG_STATUS && bus.wdata[ST_FAULT]) begin
        fault <= 1'b0;
      end
      sample_valid <= meas;
      active_method <= method;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
    end else if (bus.wr) begin
      if (bus.addr == REG_CTRL) begin
        ctrl <= bus.wdata;
      end
      if (bus.addr == REG_MASK) begin
        mask <= bus.wdata[1:0];
      end
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status <= STATUS_RESET;
    end else begin
      status <= (status & ~((bus.wr && bus.addr == REG_STATUS) ? bus.wdata[1:0] : 2'h0))
                | {viol_ev, fault_ev};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        REG_CTRL: rdata <= ctrl;
        REG_STATUS: rdata <= {30'h0, status};
        REG_MASK: rdata <= {30'h0, mask};
        REG_ACTIVE: rdata <= {11'h0, allowed, blank_len, fault, viol_cnt, method};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  strap_default_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!strap_taken && !strap.a_has_resistor) |=> strap_cfg.method == CLQ_GND_SWITCH)
    else $error("no resistor strap did not select ground sensing");
  level_decode_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!strap_taken && strap.a_has_resistor && !strap.b_is_resistor && strap.b_level == CLQ_LEVEL_OPEN)
    |=> strap_cfg.method == CLQ_WIND_DOWN && strap_cfg.viol_allowed == 5'd4)
    else $error("open level decode wrong");
  low_code_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!strap_taken && strap.a_has_resistor && strap.b_is_resistor && strap.b_code == 5'd7)
    |=> strap_cfg.method == CLQ_GND_SWITCH && strap_cfg.viol_allowed == 5'd15 && strap_cfg.blank_cycles == 8'd7)
    else $error("low code decode wrong");
  mid_code_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!strap_taken && strap.a_has_resistor && strap.b_is_resistor && strap.b_code == 5'd14)
    |=> strap_cfg.method == CLQ_WIND_DOWN && strap_cfg.viol_allowed == 5'd13 && strap_cfg.blank_cycles == 8'd4)
    else $error("middle code decode wrong");
  high_code_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!strap_taken && strap.a_has_resistor && strap.b_is_resistor && strap.b_code == 5'd21)
    |=> strap_cfg.method == CLQ_WIND_UP && strap_cfg.viol_allowed == 5'd11)
    else $error("high code decode wrong");
  blank_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    (win_start && blank_len == 8'd7 && strap_taken) |-> !meas [*7])
    else $error("measurement taken during blanking");
  fault_count_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(fault) |-> $past(viol_cnt) >= $past(allowed))
    else $error("fault before allowed count reached");
  override_a: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl[CTRL_OVR_BIT] |=> active_method == $past(ctrl[CTRL_METHOD_LSB +: 2]))
    else $error("host method not applied");
  blank_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    (win_start && strap_taken) |=> blank_cnt == $past(blank_len) - 8'd1)
    else $error("blanking not restarted at window start");
  blank_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (blank_cnt != '0) |-> !meas)
    else $error("measurement while blanking counter runs");
  sample_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    meas |=> sample_valid)
    else $error("sample valid missing after measurement");
  fault_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (fault && !(bus.wr && bus.addr == REG_STATUS && bus.wdata[ST_FAULT])) |=> fault)
    else $error("fault dropped without clear");
  irq_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    (|(status & mask)) |=> irq)
    else $error("interrupt missing for unmasked status");
  irq_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
    !(|(status & mask)) |=> !irq)
    else $error("interrupt without unmasked status");
  rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
    !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  window_only_a: assert property (@(posedge clock) disable iff (!rst_b)
    meas |-> window)
    else $error("sample outside sensing window");
  count_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
    (meas && !over_limit) |=> viol_cnt == '0)
    else $error("violation count not cleared");

  fault_seen_c: cover property (@(posedge clock) disable iff (!rst_b) $rose(fault));
  override_seen_c: cover property (@(posedge clock) disable iff (!rst_b) ctrl[CTRL_OVR_BIT] && meas);
  irq_seen_c: cover property (@(posedge clock) disable iff (!rst_b) $rose(irq));
  blank_set_c: cover property (@(posedge clock) disable iff (!rst_b)
    (ctrl[CTRL_BLANK_LSB +: BLANK_W] != '0) && meas);
  clean_clear_c: cover property (@(posedge clock) disable iff (!rst_b)
    meas && !over_limit && (viol_cnt != '0));
endmodule

/* test/clq_sense_model.sv */
// sense front end model: sensing window and comparator levels
// assumes the bench pulses go for one cycle after a rising edge
`timescale 1ns/10ps
module clq_sense_model
  import clq_pkg::*;
(
  // control from bench
  input wire logic clock,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [7:0] len,
  input wire logic over_en,
  // to the block
  output logic low_side_on,
  output logic down_slope_win,
  output logic up_slope_win,
  output logic over_limit
);
  logic [7:0] left = 8'h00;
  // window stays open for len edges after go
  always @(posedge clock) begin
    if (go) left <= len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign low_side_on = (left != 8'h00) && (sel == 2'h0);
  assign down_slope_win = (left != 8'h00) && (sel == 2'h1);
  assign up_slope_win = (left != 8'h00) && (sel == 2'h2);
  // comparator keeps its level outside windows too
  assign over_limit = over_en;
endmodule

/* test/current_limit_config_qualifier_test.sv */
// bench for the current limit qualifier
// assumes one 10 MHz clock and the sense model driving the analog side
`timescale 1ns/10ps
module current_limit_config_qualifier_test;
  import clq_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, go = 1'b0, over_en = 1'b0, sample_valid, fault, irq;
  logic low_side_on, down_slope_win, up_slope_win, over_limit;
  logic [1:0] sel = 2'h0;
  logic [7:0] len = 8'h00;
  logic [31:0] rdata, d;
  clq_strap_t strap = '0;
  clq_bus_t bus = '0;
  clq_method_t active_method;
  int bad_count = 0, checked = 0, svc = 0;
  localparam int G = BLANK_GND_CYC;
  localparam int W = BLANK_WIND_CYC;
  always #50 clock = ~clock;
  always @(posedge clock) if (sample_valid === 1'b1) svc <= svc + 1;
  clq_sense_model i_model (.clock(clock), .go(go), .sel(sel), .len(len), .over_en(over_en),
    .low_side_on(low_side_on), .down_slope_win(down_slope_win), .up_slope_win(up_slope_win),
    .over_limit(over_limit));
  clq_qualifier i_dut (.clock(clock), .rst_b(rst_b), .strap(strap), .low_side_on(low_side_on),
    .down_slope_win(down_slope_win), .up_slope_win(up_slope_win), .over_limit(over_limit),
    .bus(bus), .rdata(rdata), .active_method(active_method), .sample_valid(sample_valid),
    .fault(fault), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 v = rdata;
  endtask
  task automatic do_reset(input clq_strap_t s);
    @(posedge clock);
    rst_b <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic strap_case(input clq_strap_t s, input int m, input int bl, input int al);
    do_reset(s);
    rd_reg(REG_ACTIVE, d);
    chk({30'h0, d[1:0]}, 32'(m));
    if (bl != 0) chk({24'h0, d[15:8]}, 32'(bl));
    if (bl != 0) chk({27'h0, d[20:16]}, 32'(al));
    $display("strap case done");
  endtask
  task automatic win(input logic [1:0] s, input int n, input logic ov, input int exp);
    @(posedge clock);
    svc <= 0;
    go <= 1'b1;
    sel <= s;
    len <= 8'(n);
    over_en <= ov;
    @(posedge clock);
    go <= 1'b0;
    repeat (n + 4) @(posedge clock);
    over_en <= 1'b0;
    #1 chk(32'(svc), 32'(exp));
    $display("window test done");
  endtask
  task automatic test_done;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5ms bad_count++;
    test_done;
  end
  initial begin
    strap_case('{1'b1, 1'b0, CLQ_LEVEL_LOW, 5'h00}, 0, G, 4);
    strap_case('{1'b1, 1'b0, CLQ_LEVEL_OPEN, 5'h00}, 1, W, 4);
    strap_case('{1'b1, 1'b0, CLQ_LEVEL_HIGH, 5'h00}, 2, W, 4);
    strap_case('{1'b0, 1'b0, CLQ_LEVEL_HIGH, 5'h10}, 0, 0, 0);
    for (int c = 0; c < 24; c += 7) begin
      strap_case('{1'b1, 1'b1, CLQ_LEVEL_LOW, 5'(c)}, c / 8, (c < 8) ? G : W, 2 * (c % 8) + 1);
    end
    strap_case('{1'b1, 1'b1, CLQ_LEVEL_LOW, 5'h17}, 2, W, 15);
    do_reset('{1'b1, 1'b0, CLQ_LEVEL_LOW, 5'h00});
    wr_reg(REG_MASK, 32'h0000_0001);
    win(2'h0, 5, 1'b1, 0);
    win(2'h1, 12, 1'b1, 0);
    win(2'h0, G + 4, 1'b1, 4);
    chk({31'h0, fault}, 32'h0);
    win(2'h0, G + 2, 1'b0, 2);
    win(2'h0, G + 4, 1'b1, 4);
    chk({31'h0, fault}, 32'h0);
    win(2'h0, G + 1, 1'b0, 1);
    win(2'h0, G + 5, 1'b1, 5);
    chk({30'h0, irq, fault}, 32'h3);
    rd_reg(REG_STATUS, d);
    chk({31'h0, d[ST_FAULT]}, 32'h1);
    wr_reg(REG_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clock);
    #1 chk({30'h0, irq, fault}, 32'h0);
    rd_reg(4'hF, d);
    chk(d, 32'h0);
    wr_reg(REG_CTRL, 32'h0000_0005);
    repeat (2) @(posedge clock);
    #1 chk({30'h0, active_method}, 32'h2);
    win(2'h2, G + 3, 1'b0, 3);
    win(2'h0, G + 3, 1'b0, 0);
    wr_reg(REG_CTRL, 32'h0000_0025);
    win(2'h2, 6, 1'b0, 4);
    test_done;
  end
endmodule
